// ==== roic_pkg.sv ====
// Package with register map, field layout, codes and state type of the receiver config block
package roic_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_IO_DATA  = 12'h0e9;
    localparam logic [11:0] IDX_INT_SET  = 12'h0ea;
    localparam logic [11:0] IDX_INT_EVT  = 12'h0eb;
    localparam logic [11:0] IDX_INT_MASK = 12'h0f0;
    localparam logic [11:0] ADDR_IO_DATA  = {IDX_IO_DATA[9:0], 2'b00};
    localparam logic [11:0] ADDR_INT_SET  = {IDX_INT_SET[9:0], 2'b00};
    localparam logic [11:0] ADDR_INT_EVT  = {IDX_INT_EVT[9:0], 2'b00};
    localparam logic [11:0] ADDR_INT_MASK = {IDX_INT_MASK[9:0], 2'b00};

    // io_data_settings fields
    localparam int FMT_LSB      = 0;
    localparam int UNLOCK_SEL_B = 4;
    localparam int FORCE_AUX_B  = 5;
    localparam int MUTE_B       = 6;
    localparam int LIMIT_EN_B   = 8;
    localparam int HIGH_RANGE_B = 9;
    localparam int RATE_LSB     = 12;

    // interrupt_settings fields
    localparam int STYLE_PULSE_B = 0;
    localparam int PIN_SELECT_B  = 8;
    localparam int ERR_IRQ_EN_B  = 9;
    localparam int PCM_IRQ_EN_B  = 10;
    localparam int EMP_IRQ_EN_B  = 11;

    // Event status and mask fields
    localparam int EVT_ERR_B = 1;
    localparam int EVT_PCM_B = 2;
    localparam int EVT_EMP_B = 3;

    // Reset values
    localparam logic [15:0] IO_DATA_RST  = 16'h0000;
    localparam logic [15:0] INT_SET_RST  = 16'h0000;
    localparam logic [7:0]  INT_MASK_RST = 8'h0e;

    // Output format codes
    localparam logic [2:0] FMT_LJ24   = 3'h0;
    localparam logic [2:0] FMT_I2S24  = 3'h1;
    localparam logic [2:0] FMT_RJ24   = 3'h2;
    localparam logic [2:0] FMT_RJ20   = 3'h3;
    localparam logic [2:0] FMT_RJ16   = 3'h4;
    localparam logic [2:0] FMT_BIPH   = 3'h5;
    localparam logic [2:0] FMT_I2S28  = 3'h6;
    localparam logic [2:0] FMT_LSB28  = 3'h7;

    // Measured rate codes: 0 32k,1 44.1k,2 48k,3 64k,4 88.2k,5 96k,6 128k,7 176.4k,8 192k
    localparam logic [3:0] RATE_MAX_CODE = 4'h8;

    // Slot geometry
    localparam logic [4:0] SLOT_LAST = 5'h1f;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [15:0] io;
        logic [15:0] intc;
        logic [7:0]  mask;
        logic [7:0]  stat;
        logic        aw_ok;
        logic [11:0] aw_addr;
        logic        w_ok;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [4:0]  bit_pos;
        logic        lr;
        logic [27:0] word_l;
        logic [27:0] word_r;
        logic        fmt_bit;
        logic        sdo;
        logic        err_pin;
        logic        prev_err;
        logic        prev_pcm;
        logic        prev_emp;
        logic        pulse;
        logic        pin;
        logic        irq;
    } roic_state_s;

endpackage : roic_pkg

// ==== roic_top.sv ====
// Receiver output format, source select, rate limit and interrupt configuration block
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module roic_top (
    // Clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Receiver core status
    input  wire logic        pll_locked,
    input  wire logic [3:0]  measured_rate,
    input  wire logic        rx_error,
    input  wire logic        audio_detect,
    input  wire logic        emphasis_detect,
    // Audio data sources
    input  wire logic        bit_tick,
    input  wire logic [27:0] sample_left,
    input  wire logic [27:0] sample_right,
    input  wire logic        biphase_in,
    input  wire logic        aux_serial_in,
    // Pins
    output logic             serial_audio_out,
    output logic             lrclk_out,
    output logic             error_out,
    output logic             combined_pin_out,
    output logic             irq
);

    roic_pkg::roic_state_s s_reg;
    roic_pkg::roic_state_s s_next;

    // Accepted rate set, one bit per measured rate code
    function automatic logic [8:0] accept_mask(input logic high, input logic [3:0] code);
        logic [8:0] m;
        m = 9'h000;
        if (high) begin
            case (code)
                4'h0: m = 9'h1f8;
                4'h1: m = 9'h008;
                4'h2: m = 9'h010;
                4'h3: m = 9'h020;
                4'h4: m = 9'h080;
                4'h5: m = 9'h100;
                4'h6: m = 9'h090;
                4'h7: m = 9'h120;
                4'h8: m = 9'h038;
                default: m = 9'h000;
            endcase
        end else begin
            case (code)
                4'h0: m = 9'h03f;
                4'h1: m = 9'h001;
                4'h2: m = 9'h002;
                4'h3: m = 9'h004;
                4'h4: m = 9'h010;
                4'h5: m = 9'h020;
                4'h6: m = 9'h012;
                4'h7: m = 9'h024;
                4'h8: m = 9'h007;
                default: m = 9'h000;
            endcase
        end
        return m;
    endfunction : accept_mask

    // Bit of a 28-bit MSB-aligned word placed at slot position pos
    function automatic logic slot_bit(input logic [2:0] fmt, input logic [4:0] pos,
                                      input logic [27:0] w);
        int p;
        logic b;
        p = int'(pos);
        b = 1'b0;
        case (fmt)
            roic_pkg::FMT_LJ24:  if (p < 24) b = w[27 - p];
            roic_pkg::FMT_I2S24: if (p >= 1 && p <= 24) b = w[28 - p];
            roic_pkg::FMT_RJ24:  if (p >= 8) b = w[35 - p];
            roic_pkg::FMT_RJ20:  if (p >= 12) b = w[39 - p];
            roic_pkg::FMT_RJ16:  if (p >= 16) b = w[43 - p];
            roic_pkg::FMT_I2S28: if (p >= 1 && p <= 28) b = w[28 - p];
            roic_pkg::FMT_LSB28: if (p < 28) b = w[p];
            default: b = 1'b0;
        endcase
        return b;
    endfunction : slot_bit

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = d[7:0];
        end
        if (strb[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction : merge16

    // Combinational helpers
    logic [2:0]  fmt;
    logic [8:0]  acc;
    logic        rate_ok;
    logic        rate_err;
    logic        audio_bit;
    logic [7:0]  evt_set;
    logic [7:0]  evt_clr;
    logic [7:0]  fresh;
    logic        rd_hit;
    logic [11:0] wa;

    always_comb begin
        s_next = s_reg;
        fmt = s_reg.io[roic_pkg::FMT_LSB +: 3];
        evt_set = 8'h00;
        evt_clr = 8'h00;
        rd_hit = 1'b0;
        wa = s_reg.aw_addr;

        // Rate limiting against the selected accepted set
        acc = accept_mask(s_reg.io[roic_pkg::HIGH_RANGE_B],
                          s_reg.io[roic_pkg::RATE_LSB +: 4]);
        rate_ok = (measured_rate <= roic_pkg::RATE_MAX_CODE) && acc[measured_rate];
        rate_err = s_reg.io[roic_pkg::LIMIT_EN_B] && !rate_ok;
        s_next.err_pin = rx_error || !pll_locked || rate_err;

        // Serial slot timing; samples are latched as a new left slot begins
        if (bit_tick) begin
            s_next.bit_pos = s_reg.bit_pos + 5'h01;
            if (s_reg.bit_pos == roic_pkg::SLOT_LAST) begin
                s_next.lr = !s_reg.lr;
                if (s_reg.lr) begin
                    s_next.word_l = sample_left;
                    s_next.word_r = sample_right;
                end
            end
            s_next.fmt_bit = slot_bit(fmt, s_next.bit_pos,
                                      s_next.lr ? s_next.word_r : s_next.word_l);
        end
        audio_bit = (fmt == roic_pkg::FMT_BIPH) ? biphase_in : s_reg.fmt_bit;

        // Source selection; mute dominates, then forced aux, then unlock policy
        if (s_reg.io[roic_pkg::MUTE_B]) begin
            s_next.sdo = 1'b0;
        end else if (s_reg.io[roic_pkg::FORCE_AUX_B]) begin
            s_next.sdo = aux_serial_in;
        end else if (!pll_locked) begin
            s_next.sdo = s_reg.io[roic_pkg::UNLOCK_SEL_B] ? 1'b0 : aux_serial_in;
        end else begin
            s_next.sdo = audio_bit;
        end

        // Events, each gated by its enable
        s_next.prev_err = s_reg.err_pin;
        s_next.prev_pcm = audio_detect;
        s_next.prev_emp = emphasis_detect;
        evt_set[roic_pkg::EVT_ERR_B] = s_reg.intc[roic_pkg::ERR_IRQ_EN_B]
                                       && (s_reg.err_pin != s_reg.prev_err);
        evt_set[roic_pkg::EVT_PCM_B] = s_reg.intc[roic_pkg::PCM_IRQ_EN_B]
                                       && (audio_detect != s_reg.prev_pcm);
        evt_set[roic_pkg::EVT_EMP_B] = s_reg.intc[roic_pkg::EMP_IRQ_EN_B]
                                       && emphasis_detect && !s_reg.prev_emp;

        // Write channels taken in either order, one write in flight
        if (s_axi_awvalid && !s_reg.aw_ok) begin
            s_next.aw_ok = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_ok) begin
            s_next.w_ok = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
            s_next.aw_ok = 1'b0;
            s_next.w_ok = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = roic_pkg::RESP_OKAY;
            if (wa == roic_pkg::ADDR_IO_DATA) begin
                s_next.io = merge16(s_reg.io, s_reg.w_data, s_reg.w_strb);
            end else if (wa == roic_pkg::ADDR_INT_SET) begin
                s_next.intc = merge16(s_reg.intc, s_reg.w_data, s_reg.w_strb);
            end else if (wa == roic_pkg::ADDR_INT_MASK) begin
                if (s_reg.w_strb[0]) begin
                    s_next.mask = s_reg.w_data[7:0];
                end
            end else if (wa != roic_pkg::ADDR_INT_EVT) begin
                s_next.bresp = roic_pkg::RESP_SLVERR;
            end
        end

        // Read channel; reading the event register clears it
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.rvalid) begin
            rd_hit = 1'b1;
            s_next.rvalid = 1'b1;
            s_next.rresp = roic_pkg::RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == roic_pkg::ADDR_IO_DATA) begin
                s_next.rdata = {16'h0000, s_reg.io};
            end else if (s_axi_araddr == roic_pkg::ADDR_INT_SET) begin
                s_next.rdata = {16'h0000, s_reg.intc};
            end else if (s_axi_araddr == roic_pkg::ADDR_INT_EVT) begin
                s_next.rdata = {24'h00_0000, s_reg.stat};
                evt_clr = s_reg.stat;
            end else if (s_axi_araddr == roic_pkg::ADDR_INT_MASK) begin
                s_next.rdata = {24'h00_0000, s_reg.mask};
            end else begin
                s_next.rresp = roic_pkg::RESP_SLVERR;
            end
        end

        // A new event in the clearing cycle survives the clear
        s_next.stat = (s_reg.stat & ~evt_clr) | evt_set;
        fresh = evt_set & ~s_reg.stat & s_reg.mask;
        s_next.pulse = |fresh;
        s_next.irq = |(s_next.stat & s_reg.mask);

        // Combined pin: emphasis or interrupt, level or pulse
        if (!s_reg.intc[roic_pkg::PIN_SELECT_B]) begin
            s_next.pin = emphasis_detect;
        end else if (s_reg.intc[roic_pkg::STYLE_PULSE_B]) begin
            s_next.pin = s_next.pulse;
        end else begin
            s_next.pin = s_next.irq;
        end
    end

    // Reset value of the whole state
    localparam roic_pkg::roic_state_s STATE_RST = '{
        io:   roic_pkg::IO_DATA_RST,
        intc: roic_pkg::INT_SET_RST,
        mask: roic_pkg::INT_MASK_RST,
        default: '0
    };

    // Clock enable freezes everything, including handshakes in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= STATE_RST;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    // Ready terms depend only on held state, so valids never wait on readies here
    assign s_axi_awready    = !s_reg.aw_ok;
    assign s_axi_wready     = !s_reg.w_ok;
    assign s_axi_bvalid     = s_reg.bvalid;
    assign s_axi_bresp      = s_reg.bresp;
    assign s_axi_arready    = !s_reg.rvalid;
    assign s_axi_rvalid     = s_reg.rvalid;
    assign s_axi_rdata      = s_reg.rdata;
    assign s_axi_rresp      = s_reg.rresp;
    assign serial_audio_out = s_reg.sdo;
    assign lrclk_out        = s_reg.lr;
    assign error_out        = s_reg.err_pin;
    assign combined_pin_out = s_reg.pin;
    assign irq              = s_reg.irq;

endmodule : roic_top

// ==== roic_host_model.sv ====
// Host side model that watches the combined pin
`timescale 1ns/1ps
module roic_host_model (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Pin watched
    input  wire logic       pin,
    // High cycles seen
    output logic      [7:0] hi_cnt
);
    // Counting high cycles tells a pulse from a level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt <= 8'h00;
        end else if (pin) begin
            hi_cnt <= hi_cnt + 8'h01;
        end
    end
endmodule : roic_host_model

// ==== roic_chk.sv ====
// Concurrent checks on the ports of the receiver config block
`timescale 1ns/1ps
module roic_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Status and pins
    input wire logic        pll_locked,
    input wire logic        rx_error,
    input wire logic        error_out,
    input wire logic        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    arready_rule_a: assert property (s_axi_arready != s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && clk_en |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    aw_block_a: assert property (s_axi_awvalid && s_axi_awready && clk_en
        |=> !s_axi_awready) else $error("second write address taken");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en
        |=> s_axi_rvalid) else $error("read answer late");
    err_flag_a: assert property (clk_en && (rx_error || !pll_locked) |=> error_out)
        else $error("error flag low");
    // Level stays up until a bus access, reads clear it
    irq_hold_a: assert property (irq && clk_en && !s_axi_arvalid
        && !$past(s_axi_arvalid) && !s_axi_rvalid && !$past(s_axi_rvalid)
        && !s_axi_awvalid && !$past(s_axi_awvalid) && !s_axi_bvalid |=> irq)
        else $error("interrupt dropped without read");
endmodule : roic_chk

bind roic_top roic_chk chk_u (.*);

// ==== roic_tb_top.sv ====
// Self-checking testbench of the receiver config block
`timescale 1ns/1ps
module roic_tb_top;
    localparam logic [27:0] L  = 28'h6b3c5a7;
    // L with its bit order reversed
    localparam logic [27:0] LR = 28'he5a3cd6;
    logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, bit_tick = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf, measured_rate = 4'h6;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, tc = 2'h0;
    logic        pll_locked = 1'h1, rx_error = 1'h0, audio_detect = 1'h0;
    logic        emphasis_detect = 1'h0, biphase_in = 1'h0, aux_serial_in = 1'h0;
    logic [27:0] sample_left = L, sample_right = 28'h1234567;
    logic        serial_audio_out, lrclk_out, error_out, combined_pin_out, irq;
    logic [7:0]  hi_cnt;
    logic [33:0] v;
    // Serial data trails the slot clock by one bit, so the left slot starts at v[32]
    int          errors = 0, num_checks = 0, off = 1;
    // Rows: code, limit, measured rate, expected error flag
    logic [9:0]  rrow [16] = '{{4'h0, 1'h1, 4'h6, 1'h0}, {4'h0, 1'h1, 4'h2, 1'h1},
        {4'h1, 1'h1, 4'h3, 1'h0}, {4'h1, 1'h1, 4'h4, 1'h1}, {4'h2, 1'h1, 4'h4, 1'h0},
        {4'h3, 1'h1, 4'h5, 1'h0}, {4'h4, 1'h1, 4'h7, 1'h0}, {4'h5, 1'h1, 4'h8, 1'h0},
        {4'h6, 1'h1, 4'h7, 1'h0}, {4'h6, 1'h1, 4'h5, 1'h1}, {4'h7, 1'h1, 4'h8, 1'h0},
        {4'h8, 1'h1, 4'h3, 1'h0}, {4'h8, 1'h1, 4'h6, 1'h1}, {4'h9, 1'h1, 4'h3, 1'h1},
        {4'h9, 1'h0, 4'h3, 1'h0}, {4'h0, 1'h1, 4'h9, 1'h1}};
    // Rows: io settings, lock, aux, biphase, expected left slot
    logic [50:0] srow [12] = '{{16'h0000, 3'h4, L[27:4], 8'h00},
        {16'h0001, 3'h4, 1'h0, L[27:4], 7'h00}, {16'h0002, 3'h4, 8'h00, L[27:4]},
        {16'h0003, 3'h4, 12'h000, L[27:8]}, {16'h0004, 3'h4, 16'h0000, L[27:12]},
        {16'h0005, 3'h5, 32'hffffffff}, {16'h0006, 3'h4, 1'h0, L, 3'h0},
        {16'h0007, 3'h4, LR, 4'h0}, {16'h0020, 3'h6, 32'hffffffff},
        {16'h0000, 3'h2, 32'hffffffff}, {16'h0010, 3'h2, 32'h0}, {16'h0060, 3'h6, 32'h0}};
    // Rows: mask, interrupt settings, toggled sources, expected status
    logic [22:0] irow [10] = '{{4'he, 12'h100, 3'h1, 4'h0}, {4'he, 12'h300, 3'h1, 4'h2},
        {4'he, 12'h500, 3'h2, 4'h4}, {4'he, 12'h100, 3'h2, 4'h0},
        {4'he, 12'h900, 3'h4, 4'h8}, {4'he, 12'h200, 3'h1, 4'h2},
        {4'he, 12'h301, 3'h1, 4'h2}, {4'h0, 12'h300, 3'h1, 4'h2},
        {4'he, 12'h100, 3'h4, 4'h0}, {4'he, 12'h100, 3'h4, 4'h0}};

    roic_top dut_u (.*);
    roic_host_model host_u (.aclk(aclk), .aresetn(aresetn), .pin(combined_pin_out),
        .hi_cnt(hi_cnt));

    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        tc <= tc + 2'h1;
        bit_tick <= (tc == 2'h3);
    end

    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t word %h want %h", $time, g, e);
        end
    endtask : chk_w

    task automatic chk_b(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t bit %b want %b", $time, g, e);
        end
    endtask : chk_b

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Handshakes are judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] r);
        logic aw, w, b;
        aw = 1'h1;
        w = 1'h1;
        b = 1'h1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (b) begin
            @(negedge aclk);
            r = s_axi_bresp;
            b = !s_axi_bvalid;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] r);
        logic ar, g;
        ar = 1'h1;
        g = 1'h1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (g) begin
            @(negedge aclk);
            dt = s_axi_rdata;
            r = s_axi_rresp;
            g = !s_axi_rvalid;
            ar = ar && !s_axi_arready;
            @(posedge aclk);
            s_axi_arvalid <= ar;
            s_axi_rready <= g;
        end
    endtask : rd

    // Collects 34 bits from the start of a left slot, one per serial bit
    task automatic slot;
        logic p;
        int   i;
        p = 1'h0;
        i = -1;
        while (i < 34) begin
            do @(posedge aclk); while (bit_tick !== 1'h1);
            @(negedge aclk);
            if (i < 0 && p && !lrclk_out) i = 0;
            p = lrclk_out;
            if (i >= 0) begin
                v = {v[32:0], serial_audio_out};
                i++;
            end
        end
    endtask : slot

    task automatic irq_row(input logic [22:0] r);
        logic [7:0] c0;
        logic       e;
        wr(roic_pkg::ADDR_INT_MASK, {28'h0, r[22:19]}, rs);
        wr(roic_pkg::ADDR_INT_SET, {20'h0, r[18:7]}, rs);
        @(posedge aclk);
        {emphasis_detect, audio_detect, rx_error} <= {emphasis_detect, audio_detect,
            rx_error} ^ r[6:4];
        @(negedge aclk);
        c0 = hi_cnt;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        e = |(r[3:0] & r[22:19]);
        chk_b(irq, e);
        chk_b(combined_pin_out, r[15] ? e && !r[7] : emphasis_detect);
        if (r[7]) chk_w({24'h0, hi_cnt - c0}, 32'h1);
        rd(roic_pkg::ADDR_INT_EVT, d, rs);
        chk_w(d & 32'he, {28'h0, r[3:0]});
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk_b(irq, 1'h0);
    endtask : irq_row

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(roic_pkg::ADDR_IO_DATA, d, rs);
        chk_w(d, {16'h0, roic_pkg::IO_DATA_RST});
        rd(roic_pkg::ADDR_INT_SET, d, rs);
        chk_w(d, {16'h0, roic_pkg::INT_SET_RST});
        rd(roic_pkg::ADDR_INT_MASK, d, rs);
        chk_w(d, {24'h0, roic_pkg::INT_MASK_RST});
        rd(12'h000, d, rs);
        chk_w({d[29:0], rs}, {30'h0, roic_pkg::RESP_SLVERR});
        wr(12'h000, 32'h1, rs);
        chk_w({30'h0, rs}, {30'h0, roic_pkg::RESP_SLVERR});
        wr(roic_pkg::ADDR_IO_DATA, 32'hffff3207, rs);
        rd(roic_pkg::ADDR_IO_DATA, d, rs);
        chk_w(d, 32'h00003207);
        $display("register test done");
        // Low enable freezes the error flag until it returns
        @(posedge aclk);
        clk_en <= 1'h0;
        pll_locked <= 1'h0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk_b(error_out, 1'h0);
        @(posedge aclk);
        clk_en <= 1'h1;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk_b(error_out, 1'h1);
        @(posedge aclk);
        pll_locked <= 1'h1;
        $display("enable test done");
        foreach (rrow[k]) begin
            wr(roic_pkg::ADDR_IO_DATA, {16'h0, rrow[k][9:6], 3'h1, rrow[k][5], 8'h00}, rs);
            @(posedge aclk);
            measured_rate <= rrow[k][4:1];
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            chk_b(error_out, rrow[k][0]);
        end
        $display("rate table done");
        foreach (srow[k]) begin
            wr(roic_pkg::ADDR_IO_DATA, {16'h0, srow[k][50:35]}, rs);
            @(posedge aclk);
            {pll_locked, aux_serial_in, biphase_in} <= srow[k][34:32];
            slot();
            slot();
            chk_w(v[33 - off -: 32], srow[k][31:0]);
        end
        $display("output table done");
        foreach (irow[k]) irq_row(irow[k]);
        $display("interrupt table done");
        // Mid-run reset returns pins and registers to their reset values
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk_w({29'h0, error_out, combined_pin_out, irq}, 32'h0);
        rd(roic_pkg::ADDR_IO_DATA, d, rs);
        chk_w(d, {16'h0, roic_pkg::IO_DATA_RST});
        rd(roic_pkg::ADDR_INT_MASK, d, rs);
        chk_w(d, {24'h0, roic_pkg::INT_MASK_RST});
        chk_b(error_out, rx_error);
        $display("reset test done");
        complete_run();
    end

    // Tables need about 6500 cycles
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
endmodule : roic_tb_top
